// [cmp_event_pkg.sv]
// constants and carriers for the comparator event control block
// assumes a single clock domain and an 8-bit register port
package cmp_event_pkg;

  // register map
  localparam logic [3:0] ADDR_CTRL_STATUS = 4'h0;
  localparam logic [3:0] ADDR_IRQ_STATUS = 4'h1;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h2;

  // control/status field positions
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_REF_SELECT = 6;
  localparam int BIT_RESULT = 5;
  localparam int BIT_EVENT_FLAG = 4;
  localparam int BIT_IRQ_ENABLE = 3;
  localparam int BIT_CAPTURE_ROUTE = 2;
  localparam int BIT_MODE_HI = 1;
  localparam int BIT_MODE_LO = 0;

  // interrupt status/mask bit positions
  localparam int IRQ_BIT_EVENT = 0;
  localparam int IRQ_BIT_RISE = 1;
  localparam int IRQ_BIT_FALL = 2;
  localparam int IRQ_WIDTH = 3;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // event mode encodings
  localparam logic [1:0] MODE_TOGGLE = 2'h0;
  localparam logic [1:0] MODE_RESERVED = 2'h1;
  localparam logic [1:0] MODE_FALL = 2'h2;
  localparam logic [1:0] MODE_RISE = 2'h3;

  // register bus request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // control fields as held by software
  typedef struct packed {
    logic power_off;
    logic ref_select;
    logic irq_enable;
    logic capture_route;
    logic [1:0] mode;
  } ctrl_t;

endpackage

// [comparator_event_control.sv]
// comparator event control: sync, edge detect, flag, irq, capture route
// assumes an analog core outside that compares the two selected inputs
// Function
// - result high when positive exceeds negative
// - result synchronised, lags one to two cycles
// - power-off bit seven shuts comparator down
// - reference select picks bandgap or pin
// - matching event sets flag bit four
// - irq needs flag, enable, global enable; block irq output needs only a status bit and its mask bit
// - flag clears on interrupt vector entry
// - writing one clears flag, zero keeps
// - capture-route bit connects result to timer
// - mode field selects toggle, fall, rise
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/10ps
module comparator_event_control
  import cmp_event_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire reg_req_t req,
  output logic [7:0] rdata,
  // analog core
  input wire logic cmp_raw,
  output logic cmp_power_off,
  output logic cmp_ref_select,
  // cpu interrupt interface
  input wire logic cpu_global_irq_enable,
  input wire logic cmp_vector_ack,
  output logic cmp_irq_req,
  // timer capture front end
  output logic cmp_capture_out,
  // block interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // synchroniser and edge detection

  logic sync1_r, sync2_r, prev_r;
  logic sync1_nxt, sync2_nxt, prev_nxt;
  logic rise, fall, toggle;

  always_comb
  begin
    sync1_nxt = cmp_raw;
    sync2_nxt = sync1_r;
    prev_nxt = sync2_r;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end
    else
    begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  assign toggle = sync2_r ^ prev_r;

  ////////////////////////////////////////////////////////////////////////
  // readable comparator result

  logic cmp_result;

  assign cmp_result = sync2_r;

  ////////////////////////////////////////////////////////////////////////
  // control register and event flag

  ctrl_t ctrl_r, ctrl_nxt;
  logic flag_r, flag_nxt;
  logic mode_hit;
  logic wr_ctrl;

  assign wr_ctrl = req.wr && req.addr == ADDR_CTRL_STATUS;

  always_comb
  begin
    unique case (ctrl_r.mode)
      MODE_TOGGLE: mode_hit = toggle;
      MODE_FALL: mode_hit = fall;
      MODE_RISE: mode_hit = rise;
      MODE_RESERVED: mode_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    flag_nxt = flag_r;
    if (wr_ctrl)
    begin
      ctrl_nxt.power_off = req.wdata[BIT_POWER_OFF];
      ctrl_nxt.ref_select = req.wdata[BIT_REF_SELECT];
      ctrl_nxt.irq_enable = req.wdata[BIT_IRQ_ENABLE];
      ctrl_nxt.capture_route = req.wdata[BIT_CAPTURE_ROUTE];
      ctrl_nxt.mode = req.wdata[BIT_MODE_HI:BIT_MODE_LO];
      if (req.wdata[BIT_EVENT_FLAG])
        flag_nxt = 1'b0;
    end
    if (cmp_vector_ack)
      flag_nxt = 1'b0;
    // matching event sets flag, wins over clear
    if (mode_hit)
      flag_nxt = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ctrl_r <= ctrl_t'({CTRL_RESET[BIT_POWER_OFF],
        CTRL_RESET[BIT_REF_SELECT], CTRL_RESET[BIT_IRQ_ENABLE],
        CTRL_RESET[BIT_CAPTURE_ROUTE],
        CTRL_RESET[BIT_MODE_HI:BIT_MODE_LO]});
      flag_r <= CTRL_RESET[BIT_EVENT_FLAG];
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      flag_r <= flag_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // block interrupt status and mask

  logic [IRQ_WIDTH-1:0] ist_r, ist_nxt, imask_r, imask_nxt;
  logic [IRQ_WIDTH-1:0] ev;
  logic rd_ist;

  assign ev[IRQ_BIT_EVENT] = mode_hit;
  assign ev[IRQ_BIT_RISE] = rise;
  assign ev[IRQ_BIT_FALL] = fall;
  assign rd_ist = req.rd && req.addr == ADDR_IRQ_STATUS;

  always_comb
  begin
    imask_nxt = imask_r;
    if (req.wr && req.addr == ADDR_IRQ_MASK)
      imask_nxt = req.wdata[IRQ_WIDTH-1:0];
    // read clears, new events set in the same cycle
    ist_nxt = (rd_ist ? IRQ_RESET : ist_r) | ev;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      ist_r <= IRQ_RESET;
      imask_r <= IRQ_RESET;
    end
    else
    begin
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
    end
  end

  assign irq = |(ist_r & imask_r);

  ////////////////////////////////////////////////////////////////////////
  // read data

  logic [7:0] rdata_r, rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (req.rd)
    begin
      unique case (req.addr)
        ADDR_CTRL_STATUS:
        begin
          rdata_nxt[BIT_POWER_OFF] = ctrl_r.power_off;
          rdata_nxt[BIT_REF_SELECT] = ctrl_r.ref_select;
          rdata_nxt[BIT_RESULT] = cmp_result;
          rdata_nxt[BIT_EVENT_FLAG] = flag_r;
          rdata_nxt[BIT_IRQ_ENABLE] = ctrl_r.irq_enable;
          rdata_nxt[BIT_CAPTURE_ROUTE] = ctrl_r.capture_route;
          rdata_nxt[BIT_MODE_HI:BIT_MODE_LO] = ctrl_r.mode;
        end
        ADDR_IRQ_STATUS: rdata_nxt[IRQ_WIDTH-1:0] = ist_r;
        ADDR_IRQ_MASK: rdata_nxt[IRQ_WIDTH-1:0] = imask_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////
  // outputs to core, cpu and timer

  logic irq_req_r, irq_req_nxt, cap_r, cap_nxt;

  always_comb
  begin
    irq_req_nxt = flag_nxt & ctrl_nxt.irq_enable & cpu_global_irq_enable;
    // route result to capture only when enabled
    cap_nxt = ctrl_r.capture_route & cmp_result;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      irq_req_r <= 1'b0;
      cap_r <= 1'b0;
    end
    else
    begin
      irq_req_r <= irq_req_nxt;
      cap_r <= cap_nxt;
    end
  end

  assign cmp_power_off = ctrl_r.power_off;
  assign cmp_ref_select = ctrl_r.ref_select;
  // registered request to cpu and level to timer capture
  assign cmp_irq_req = irq_req_r;
  assign cmp_capture_out = cap_r;

endmodule

// [cmp_event_asserts.sv]
// port checker for the comparator event block
// assumes the bench keeps strobes apart
`timescale 1ns/10ps
module cmp_event_asserts
  import cmp_event_pkg::*;
(
  // watched ports
  input wire logic mclk,
  input wire logic rst,
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire logic cmp_raw,
  input wire logic cmp_power_off,
  input wire logic cmp_ref_select,
  input wire logic cpu_global_irq_enable,
  input wire logic cmp_vector_ack,
  input wire logic cmp_irq_req,
  input wire logic cmp_capture_out,
  input wire logic irq
);
  logic wc;
  assign wc = req.wr && req.addr == ADDR_CTRL_STATUS;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  rdata_idle_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("rdata outside read");
  irq_gate_a: assert property (
    cmp_irq_req |-> $past(cpu_global_irq_enable)) else $error("no gie");
  enable_off_a: assert property (
    wc && !req.wdata[BIT_IRQ_ENABLE] ##1 !req.wr |=> !cmp_irq_req)
    else $error("irq while disabled");
  power_off_a: assert property (
    wc |=> cmp_power_off == $past(req.wdata[BIT_POWER_OFF]))
    else $error("power off lag");
  ref_sel_a: assert property (
    wc |=> cmp_ref_select == $past(req.wdata[BIT_REF_SELECT]))
    else $error("ref select lag");
  route_off_a: assert property (
    wc && !req.wdata[BIT_CAPTURE_ROUTE] |-> ##2 !cmp_capture_out)
    else $error("capture not cut");
  capture_pol_a: assert property (
    cmp_capture_out |-> $past(cmp_raw, 2) || $past(cmp_raw, 3) ||
    $past(cmp_raw, 4)) else $error("capture polarity");
  mask_off_a: assert property (req.wr && req.addr == ADDR_IRQ_MASK &&
    req.wdata[2:0] == 3'h0 |=> !irq) else $error("irq masked");
  cover property ($rose(cmp_irq_req));
  cover property ($rose(irq));
  cover property ($rose(cmp_capture_out));
endmodule
bind comparator_event_control cmp_event_asserts i_chk (.*);

// [cmp_analog_model.sv]
// analog comparator core with bandgap mux
// assumes levels given as unsigned codes
`timescale 1ns/10ps
module cmp_analog_model #(parameter logic [7:0] BANDGAP = 8'h80)
(
  // levels and controls
  input wire logic [7:0] pos_lvl,
  input wire logic [7:0] neg_lvl,
  input wire logic power_off,
  input wire logic ref_select,
  // decision
  output logic cmp_raw
);
  assign cmp_raw = !power_off &&
    ((ref_select ? BANDGAP : pos_lvl) > neg_lvl);
endmodule

// [test_comparator_event_control.sv]
// bench: register tasks, read scoreboard, analog model
// assumes package, model and checker compiled first
`timescale 1ns/10ps
module test_comparator_event_control
  import cmp_event_pkg::*;
;
  localparam logic [3:0] CS = ADDR_CTRL_STATUS;
  logic mclk = 0, rst = 1, cmp_vector_ack = 0;
  logic cpu_global_irq_enable = 1, rd_d = 0, f;
  logic cmp_raw, cmp_power_off, cmp_ref_select, cmp_irq_req;
  logic cmp_capture_out, irq;
  logic [7:0] rdata, pos = 8'h10, exp_q[$];
  reg_req_t req = '0;
  int fail_count = 0, num_checks = 0, seed = 95580;
  comparator_event_control i_dut (.*);
  cmp_analog_model i_core (.pos_lvl(pos), .neg_lvl(8'h40),
    .power_off(cmp_power_off), .ref_select(cmp_ref_select),
    .cmp_raw(cmp_raw));
  task automatic check(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    exp_q.push_back(e);
    @(posedge mclk);
  endtask
  task automatic wt(input int n);
    req <= '0;
    repeat (n) @(posedge mclk);
  endtask
  task automatic summarize;
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (rd_d)
      check(rdata, exp_q.pop_front());
    rd_d <= req.rd;
  end
  initial
  begin
    repeat (2000) @(posedge mclk);
    fail_count++;
    summarize;
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    for (int a = 0; a < 4; a++)
      rd(a == 3 ? 4'hf : a[3:0], 8'h00);
    for (int m = 0; m < 4; m++)
    begin
      wr(CS, 8'h10 | m[7:0]);
      wr(CS, 8'h08 | m[7:0]);
      cpu_global_irq_enable <= (m != 3);
      pos <= 8'h41 + ($random(seed) & 8'h3f);
      wt(6);
      f = (m == 0 || m == 3);
      check(cmp_irq_req, f && m != 3);
      rd(CS, {3'b001, f, 2'b10, m[1:0]});
      pos <= $random(seed) & 8'h3f;
      wt(6);
      f = f || m == 0 || m == 2;
      rd(CS, {3'b000, f, 2'b10, m[1:0]});
    end
    wr(ADDR_IRQ_MASK, 8'h07);
    wt(1);
    check(irq, 1);
    wr(ADDR_IRQ_MASK, 8'h00);
    wt(1);
    check(irq, 0);
    wr(ADDR_IRQ_MASK, 8'h07);
    rd(ADDR_IRQ_STATUS, 8'h07);
    wt(2);
    check(irq, 0);
    rd(ADDR_IRQ_STATUS, 8'h00);
    rd(ADDR_IRQ_MASK, 8'h07);
    wr(CS, 8'h18);
    cpu_global_irq_enable <= 1;
    pos <= 8'hc0;
    wt(6);
    check(cmp_irq_req, 1);
    cmp_vector_ack <= 1;
    wt(1);
    cmp_vector_ack <= 0;
    wt(2);
    check(cmp_irq_req, 0);
    rd(CS, 8'h28);
    pos <= 8'h10;
    wt(6);
    wr(CS, 8'h08);
    rd(CS, 8'h18);
    wr(CS, 8'h18);
    rd(CS, 8'h08);
    wr(CS, 8'h10);
    pos <= 8'hc0;
    // timer side owns its capture irq enable
    wr(CS, 8'h04);
    wt(6);
    check(cmp_capture_out, 1);
    wr(CS, 8'h84);
    wt(6);
    check(cmp_capture_out, 0);
    rd(CS, 8'h94);
    pos <= 8'h10;
    wr(CS, 8'h54);
    wt(6);
    check(cmp_capture_out, 1);
    rd(CS, 8'h74);
    wt(3);
    summarize;
  end
endmodule
